// ### verilog/flh_pkg.sv
package flh_pkg;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;

  // Command codes on the user port
  typedef enum logic [2:0] {
    CMD_RESET,
    CMD_QUERY,
    CMD_AUTOSEL,
    CMD_CHIP,
    CMD_BLOCK,
    CMD_SUSP,
    CMD_RESUME,
    CMD_READ
  } flh_cmd_e;

  // Host model of the device mode
  typedef enum logic [3:0] {
    MD_READ,
    MD_AUTO,
    MD_QRY,
    MD_QRY_AUTO,
    MD_CHIP,
    MD_BTMO,
    MD_BERASE,
    MD_ESUSP,
    MD_ESUSP_AUX,
    MD_ERR
  } flh_mode_e;

  // Bus write data codes
  localparam logic [7:0] CD_UNLK1 = 8'hAA;
  localparam logic [7:0] CD_UNLK2 = 8'h55;
  localparam logic [7:0] CD_SETUP = 8'h80;
  localparam logic [7:0] CD_CHIP = 8'h10;
  localparam logic [7:0] CD_BLOCK = 8'h30;
  localparam logic [7:0] CD_SUSP = 8'hB0;
  localparam logic [7:0] CD_RESUME = 8'h30;
  localparam logic [7:0] CD_QUERY = 8'h98;
  localparam logic [7:0] CD_RESET = 8'hF0;
  localparam logic [7:0] CD_AUTO = 8'h90;

  // Unlock addresses
  localparam logic [ADDR_W-1:0] AD_UNLK1 = 23'h000555;
  localparam logic [ADDR_W-1:0] AD_UNLK2 = 23'h0002AA;

  // Sequence word indices
  localparam logic [2:0] IDX_FIRST = 3'h0;
  localparam logic [2:0] IDX_AUTO_LAST = 3'h2;
  localparam logic [2:0] IDX_SIXTH = 3'h5;
  localparam logic [2:0] IDX_SINGLE = 3'h6;

  // Status register error bit
  localparam int ST_ERR_BIT = 5;
  // Poll bit reads low in status, high in erased array
  localparam int ST_POLL_BIT = 7;

  // Timing
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int BLK_TMO_US = 50;
  localparam int BLK_TMO_CYC = BLK_TMO_US * 1000 / CLK_NS;

endpackage

// ### verilog/flh_bus.sv
`timescale 1ns/1ns
module flh_bus #(
  parameter int WP_CYC = flh_pkg::WP_CYC,
  parameter int ACC_CYC = flh_pkg::ACC_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic wr_i,
  input wire logic [flh_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flh_pkg::DATA_W-1:0] wdata_i,
  output logic done_o,
  output logic [flh_pkg::DATA_W-1:0] rdata_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [flh_pkg::ADDR_W-1:0] addr_o,
  output logic [flh_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [flh_pkg::DATA_W-1:0] dq_i
);

  initial begin
    if (WP_CYC < 1 || ACC_CYC < 1 || WP_CYC > 255 || ACC_CYC > 250) begin
      $error("flh_bus: strobe lengths out of range");
    end
  end

  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_RECOV} flh_bst_e;

  flh_bst_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic dq_oe_q, dq_oe_d, done_q, done_d;
  logic [flh_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [flh_pkg::DATA_W-1:0] dq_q, dq_d, rdata_q, rdata_d;
  logic [flh_pkg::DATA_W-1:0] dq_m_q, dq_s_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dq_oe_d = dq_oe_q;
    addr_d = addr_q;
    dq_d = dq_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    unique case (st_q)
      B_IDLE: begin
        if (start_i) begin
          wr_d = wr_i;
          addr_d = addr_i;
          dq_d = wdata_i;
          dq_oe_d = wr_i;
          ce_n_d = 1'b0;
          st_d = B_SETUP;
        end
      end
      B_SETUP: begin
        we_n_d = !wr_q;
        oe_n_d = wr_q;
        // Read strobe covers access time plus input synchroniser
        cnt_d = wr_q ? 8'(WP_CYC - 1) : 8'(ACC_CYC + flh_pkg::SYNC_CYC - 1);
        st_d = B_STROBE;
      end
      B_STROBE: begin
        if (cnt_q == 8'h00) begin
          if (!wr_q) begin
            rdata_d = dq_s_q;
          end
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          st_d = B_RECOV;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      B_RECOV: begin
        ce_n_d = 1'b1;
        dq_oe_d = 1'b0;
        done_d = 1'b1;
        st_d = B_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= B_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
      addr_q <= '0;
      dq_q <= '0;
      rdata_q <= '0;
      done_q <= 1'b0;
      dq_m_q <= '0;
      dq_s_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dq_oe_q <= dq_oe_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      dq_m_q <= dq_i;
      dq_s_q <= dq_m_q;
    end
  end

  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign ce_n_o = ce_n_q;
  assign oe_n_o = oe_n_q;
  assign we_n_o = we_n_q;
  assign addr_o = addr_q;
  assign dq_o = dq_q;
  assign dq_oe_o = dq_oe_q;

endmodule

// ### verilog/flh_ctrl.sv
// Operation
// - Query write moves device to query mode; reads return info area.
// - Reset leaves query to prior mode; from auto-select reset again.
// - Chip erase is a six-write sequence setting unprotected blocks to one.
// - Clean finish returns read mode; after error reset clears it.
// - Hardware reset aborts chip erase; repeat the whole erase.
// - Block erase six writes; more blocks by repeating sixth write.
// - Suspend allows auto-select and query; reset before resume.
// - Extended block readable in suspend; exit it before resume.
// - Query is 98 at bank address; reset is F0, optionally unlocked.
// - Erases: unlock, 80, unlock, then 10 fixed or 30 at block.
// - Suspend is B0 and resume is 30, each at a bank address.
`timescale 1ns/1ns
module flh_ctrl #(
  parameter int BLK_TMO_CYC = flh_pkg::BLK_TMO_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_i,
  input wire logic [flh_pkg::ADDR_W-1:0] addr_i,
  output logic ready_o,
  output logic done_o,
  output logic refused_o,
  output logic fail_o,
  output logic [flh_pkg::DATA_W-1:0] rdata_o,
  output logic [3:0] mode_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_rst_n_o,
  output logic [flh_pkg::ADDR_W-1:0] flash_addr_o,
  output logic [flh_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [flh_pkg::DATA_W-1:0] flash_dq_i,
  input wire logic flash_rb_i
);

  initial begin
    if (BLK_TMO_CYC < 1 || BLK_TMO_CYC > 32'h00FFFFFF) begin
      $error("flh_ctrl: BLK_TMO_CYC out of range");
    end
  end

  typedef enum logic [2:0] {
    S_IDLE, S_WRITE, S_WWAIT, S_READ, S_RWAIT, S_POLL, S_STAT, S_SWAIT
  } flh_st_e;

  localparam int AW = flh_pkg::ADDR_W;

  // Host-side acceptance table, mirrors what the device would honour
  function automatic logic legal(flh_pkg::flh_cmd_e c,
                                 flh_pkg::flh_mode_e m);
    unique case (c)
      flh_pkg::CMD_READ: legal = 1'b1;
      flh_pkg::CMD_RESET: legal = !(m inside {flh_pkg::MD_CHIP,
                                              flh_pkg::MD_BERASE});
      flh_pkg::CMD_QUERY: legal = m inside {flh_pkg::MD_READ,
        flh_pkg::MD_AUTO, flh_pkg::MD_ESUSP, flh_pkg::MD_ESUSP_AUX};
      flh_pkg::CMD_AUTOSEL: legal = m inside {flh_pkg::MD_READ,
                                              flh_pkg::MD_ESUSP};
      flh_pkg::CMD_CHIP: legal = m == flh_pkg::MD_READ;
      flh_pkg::CMD_BLOCK: legal = m inside {flh_pkg::MD_READ,
                                            flh_pkg::MD_BTMO};
      flh_pkg::CMD_SUSP: legal = m inside {flh_pkg::MD_BTMO,
                                           flh_pkg::MD_BERASE};
      flh_pkg::CMD_RESUME: legal = m == flh_pkg::MD_ESUSP;
    endcase
  endfunction

  function automatic flh_pkg::flh_mode_e next_mode(flh_pkg::flh_cmd_e c,
      flh_pkg::flh_mode_e m);
    next_mode = m;
    unique case (c)
      flh_pkg::CMD_RESET: begin
        unique case (m)
          flh_pkg::MD_QRY_AUTO: next_mode = flh_pkg::MD_AUTO;
          flh_pkg::MD_ESUSP_AUX: next_mode = flh_pkg::MD_ESUSP;
          flh_pkg::MD_ESUSP: next_mode = flh_pkg::MD_ESUSP;
          default: next_mode = flh_pkg::MD_READ;
        endcase
      end
      flh_pkg::CMD_QUERY: next_mode = (m == flh_pkg::MD_READ) ?
        flh_pkg::MD_QRY : (m == flh_pkg::MD_AUTO) ?
        flh_pkg::MD_QRY_AUTO : flh_pkg::MD_ESUSP_AUX;
      flh_pkg::CMD_AUTOSEL: next_mode = (m == flh_pkg::MD_READ) ?
        flh_pkg::MD_AUTO : flh_pkg::MD_ESUSP_AUX;
      flh_pkg::CMD_CHIP: next_mode = flh_pkg::MD_CHIP;
      flh_pkg::CMD_BLOCK: next_mode = flh_pkg::MD_BTMO;
      flh_pkg::CMD_SUSP: next_mode = flh_pkg::MD_ESUSP;
      flh_pkg::CMD_RESUME: next_mode = flh_pkg::MD_BERASE;
      flh_pkg::CMD_READ: next_mode = m;
    endcase
  endfunction

  // Address and code byte of one bus write of a sequence
  function automatic logic [AW+7:0] word(flh_pkg::flh_cmd_e c,
      logic [2:0] idx, logic [AW-1:0] a);
    unique case (idx)
      3'h0, 3'h3: word = {flh_pkg::AD_UNLK1, flh_pkg::CD_UNLK1};
      3'h1, 3'h4: word = {flh_pkg::AD_UNLK2, flh_pkg::CD_UNLK2};
      3'h2: word = (c == flh_pkg::CMD_AUTOSEL) ? {a, flh_pkg::CD_AUTO} :
                   {flh_pkg::AD_UNLK1, flh_pkg::CD_SETUP};
      3'h5: word = (c == flh_pkg::CMD_CHIP) ?
                   {flh_pkg::AD_UNLK1, flh_pkg::CD_CHIP} :
                   {a, flh_pkg::CD_BLOCK};
      default: begin
        unique case (c)
          flh_pkg::CMD_QUERY: word = {a, flh_pkg::CD_QUERY};
          flh_pkg::CMD_SUSP: word = {a, flh_pkg::CD_SUSP};
          flh_pkg::CMD_RESUME: word = {a, flh_pkg::CD_RESUME};
          default: word = {a, flh_pkg::CD_RESET};
        endcase
      end
    endcase
  endfunction

  flh_st_e st_q, st_d;
  flh_pkg::flh_mode_e mode_q, mode_d;
  flh_pkg::flh_cmd_e cmd_q, cmd_d, cmd_in;
  logic [2:0] idx_q, idx_d, last_q, last_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [23:0] tmo_q, tmo_d;
  logic seen_q, seen_d, ready_q, ready_d, done_q, done_d;
  logic ref_q, ref_d, fail_q, fail_d, frst_n_q;
  logic [flh_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic rb_m_q, rb_s_q;
  logic take, erasing;
  logic bstart, bwr, bdone;
  logic [AW+7:0] bword;
  logic [flh_pkg::DATA_W-1:0] brdata;

  assign cmd_in = flh_pkg::flh_cmd_e'(cmd_i);
  assign take = cmd_valid_i && ready_q;
  assign erasing = mode_q inside {flh_pkg::MD_CHIP, flh_pkg::MD_BERASE};

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    cmd_d = cmd_q;
    idx_d = idx_q;
    last_d = last_q;
    addr_d = addr_q;
    tmo_d = tmo_q;
    rdata_d = rdata_q;
    fail_d = fail_q;
    done_d = 1'b0;
    ref_d = 1'b0;
    bstart = 1'b0;
    bwr = 1'b0;
    bword = word(cmd_q, idx_q, addr_q);
    // Busy must be seen before ready can mean finished
    seen_d = erasing && (seen_q || !rb_s_q);
    if (mode_q == flh_pkg::MD_BTMO && tmo_q != 24'h000000) begin
      tmo_d = tmo_q - 24'h000001;
    end
    unique case (st_q)
      S_IDLE: begin
        if (take) begin
          if (!legal(cmd_in, mode_q)) begin
            ref_d = 1'b1;
          end else begin
            cmd_d = cmd_in;
            addr_d = addr_i;
            mode_d = next_mode(cmd_in, mode_q);
            idx_d = (cmd_in inside {flh_pkg::CMD_CHIP, flh_pkg::CMD_AUTOSEL})
                    ? flh_pkg::IDX_FIRST : flh_pkg::IDX_SINGLE;
            last_d = (cmd_in == flh_pkg::CMD_AUTOSEL) ?
                     flh_pkg::IDX_AUTO_LAST : (cmd_in == flh_pkg::CMD_CHIP) ?
                     flh_pkg::IDX_SIXTH : flh_pkg::IDX_SINGLE;
            if (cmd_in == flh_pkg::CMD_BLOCK) begin
              idx_d = (mode_q == flh_pkg::MD_BTMO) ? flh_pkg::IDX_SIXTH :
                      flh_pkg::IDX_FIRST;
              last_d = flh_pkg::IDX_SIXTH;
              tmo_d = 24'(BLK_TMO_CYC);
            end
            if (cmd_in == flh_pkg::CMD_RESET) begin
              fail_d = 1'b0;
            end
            st_d = (cmd_in == flh_pkg::CMD_READ) ? S_READ : S_WRITE;
          end
        end else if (erasing && seen_q && rb_s_q) begin
          st_d = S_STAT;
        end else if (mode_q == flh_pkg::MD_BTMO && tmo_q == 24'h000000) begin
          mode_d = flh_pkg::MD_BERASE;
        end
      end
      S_WRITE: begin
        bstart = 1'b1;
        bwr = 1'b1;
        st_d = S_WWAIT;
      end
      S_WWAIT: begin
        if (bdone) begin
          if (idx_q == last_q) begin
            st_d = (cmd_q == flh_pkg::CMD_SUSP) ? S_POLL : S_IDLE;
            done_d = cmd_q != flh_pkg::CMD_SUSP;
          end else begin
            idx_d = idx_q + 3'h1;
            st_d = S_WRITE;
          end
        end
      end
      S_READ, S_STAT: begin
        bstart = 1'b1;
        bword = {addr_q, 8'h00};
        st_d = (st_q == S_READ) ? S_RWAIT : S_SWAIT;
      end
      S_RWAIT: begin
        if (bdone) begin
          rdata_d = brdata;
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_POLL: begin
        if (rb_s_q) begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_SWAIT: begin
        if (bdone) begin
          // status decides read mode or error
          rdata_d = brdata;
          // Erased array reads all ones, so bit 5 alone is ambiguous
          fail_d = brdata[flh_pkg::ST_ERR_BIT] &&
                   !brdata[flh_pkg::ST_POLL_BIT];
          mode_d = fail_d ? flh_pkg::MD_ERR : flh_pkg::MD_READ;
          st_d = S_IDLE;
        end
      end
    endcase
    ready_d = st_d == S_IDLE;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      mode_q <= flh_pkg::MD_READ;
      cmd_q <= flh_pkg::CMD_RESET;
      idx_q <= 3'h0;
      last_q <= 3'h0;
      addr_q <= '0;
      tmo_q <= 24'h000000;
      seen_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      ref_q <= 1'b0;
      fail_q <= 1'b0;
      rdata_q <= '0;
      rb_m_q <= 1'b0;
      rb_s_q <= 1'b0;
      // flash held in reset, aborting any erase
      frst_n_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cmd_q <= cmd_d;
      idx_q <= idx_d;
      last_q <= last_d;
      addr_q <= addr_d;
      tmo_q <= tmo_d;
      seen_q <= seen_d;
      ready_q <= ready_d;
      done_q <= done_d;
      ref_q <= ref_d;
      fail_q <= fail_d;
      rdata_q <= rdata_d;
      rb_m_q <= flash_rb_i;
      rb_s_q <= rb_m_q;
      frst_n_q <= 1'b1;
    end
  end

  flh_bus u_bus (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(bstart),
    .wr_i(bwr),
    .addr_i(bword[AW+7:8]),
    .wdata_i({8'h00, bword[7:0]}),
    .done_o(bdone),
    .rdata_o(brdata),
    .ce_n_o(flash_ce_n_o),
    .oe_n_o(flash_oe_n_o),
    .we_n_o(flash_we_n_o),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o),
    .dq_i(flash_dq_i)
  );

  assign ready_o = ready_q;
  assign done_o = done_q;
  assign refused_o = ref_q;
  assign fail_o = fail_q;
  assign rdata_o = rdata_q;
  assign mode_o = mode_q;
  assign flash_rst_n_o = frst_n_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_take(flh_pkg::flh_cmd_e c, flh_pkg::flh_mode_e m);
    take && cmd_in == c && mode_q == m;
  endsequence

  property p_query_mode;
    s_take(flh_pkg::CMD_QUERY, flh_pkg::MD_READ) |=>
      mode_q == flh_pkg::MD_QRY && st_q == S_WRITE;
  endproperty
  a_query_mode: assert property (p_query_mode) else $error("query mode");
  property p_query_back;
    s_take(flh_pkg::CMD_RESET, flh_pkg::MD_QRY_AUTO) |=>
      mode_q == flh_pkg::MD_AUTO;
  endproperty
  a_query_back: assert property (p_query_back) else $error("query exit");
  property p_chip_seq;
    s_take(flh_pkg::CMD_CHIP, flh_pkg::MD_READ) |=>
      idx_q == 3'h0 && last_q == 3'h5;
  endproperty
  a_chip_seq: assert property (p_chip_seq) else $error("chip seq");
  property p_chip_deaf;
    cmd_valid_i && ready_q && mode_q == flh_pkg::MD_CHIP &&
      cmd_in != flh_pkg::CMD_READ |=> refused_o ##1 !refused_o;
  endproperty
  a_chip_deaf: assert property (p_chip_deaf) else $error("chip deaf");
  property p_err_clear;
    s_take(flh_pkg::CMD_RESET, flh_pkg::MD_ERR) |=>
      !fail_o && mode_q == flh_pkg::MD_READ;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("err clear");
  property p_add_block;
    s_take(flh_pkg::CMD_BLOCK, flh_pkg::MD_BTMO) |=>
      idx_q == 3'h5 && tmo_q == 24'(BLK_TMO_CYC);
  endproperty
  a_add_block: assert property (p_add_block) else $error("add block");
  property p_tmo_end;
    mode_q == flh_pkg::MD_BTMO && tmo_q == 24'h000000 && st_q == S_IDLE
      && !take |=> mode_q == flh_pkg::MD_BERASE;
  endproperty
  a_tmo_end: assert property (p_tmo_end) else $error("timeout end");
  property p_berase_rst;
    cmd_valid_i && ready_q && cmd_in == flh_pkg::CMD_RESET &&
      mode_q == flh_pkg::MD_BERASE |=> refused_o;
  endproperty
  a_berase_rst: assert property (p_berase_rst) else $error("reset taken");
  property p_resume_aux;
    cmd_valid_i && ready_q && cmd_in == flh_pkg::CMD_RESUME &&
      mode_q != flh_pkg::MD_ESUSP |=> refused_o && $stable(mode_q);
  endproperty
  a_resume_aux: assert property (p_resume_aux) else $error("resume");
  property p_resume;
    s_take(flh_pkg::CMD_RESUME, flh_pkg::MD_ESUSP) |=>
      mode_q == flh_pkg::MD_BERASE ##1 st_q == S_WWAIT;
  endproperty
  a_resume: assert property (p_resume) else $error("resume mode");

endmodule

// ### sim/flh_flash_model.sv
`timescale 1ns/1ns
module flh_flash_model #(
  parameter int TMO_NS = 2000,
  parameter int BUSY_NS = 3000,
  parameter logic [15:0] CFI_V = 16'h0051,
  // Arbitrary identification word
  parameter logic [15:0] ID_V = 16'h1234
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rst_n_i,
  input wire logic err_i,
  input wire logic [flh_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flh_pkg::DATA_W-1:0] dq_i,
  output logic [flh_pkg::DATA_W-1:0] dq_o,
  output logic rb_o
);
  // 0 read, 1 auto, 2 query, 4 chip, 5 window, 6 erase, 7 held, 9 fault
  int md = 0;
  int prv = 0;
  int seq = 0;
  int tmr = 0;
  logic erased = 0;
  logic [1:0] bank = 0;
  logic [7:0] d;
  logic [15:0] rd;
  logic [15:0] last = 0;
  always_comb begin
    if (md == 4 || md == 9 || (md inside {5, 6, 7} && addr_i[22:21] == bank))
      rd = {10'h000, md == 9, 5'h00} | 16'h0040;
    else if (md == 2)
      rd = CFI_V;
    else if (md == 1)
      rd = ID_V;
    else
      rd = erased ? 16'hFFFF : addr_i[15:0];
  end
  assign rb_o = !(md inside {4, 5, 6});
  always @(posedge oe_n_i) last = rd;
  // Released bus must not keep the last word
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
  always @(posedge we_n_i or negedge rst_n_i) begin
    d = dq_i[7:0];
    if (!rst_n_i) begin
      md = 0;
      seq = 0;
      tmr = 0;
    end else if (!ce_n_i && md != 4) begin
      if (d == 8'hF0 && md != 6) begin
        md = (md == 2) ? prv : (md == 7 ? 7 : 0);
        seq = 0;
      end else if (d == 8'h98 && md inside {0, 1, 7}) begin
        prv = md;
        md = 2;
      end else if (d == 8'hB0 && md inside {5, 6}) begin
        // suspend ends window, no program here
        md = 7;
      end else if (d == 8'h30 && md inside {5, 7}) begin
        tmr = 0;
        if (md == 7) md = 6;
      end else if (md inside {0, 1}) begin
        case (seq)
          0: seq = (d == 8'hAA) ? 1 : 0;
          1: seq = (d == 8'h55) ? 2 : 0;
          2: begin
            seq = (d == 8'h80) ? 3 : 0;
            if (d == 8'h90) md = 1;
          end
          3: seq = (d == 8'hAA) ? 4 : 0;
          4: seq = (d == 8'h55) ? 5 : 0;
          default: begin
            seq = 0;
            tmr = 0;
            bank = addr_i[22:21];
            if (d == 8'h10) md = 4;
            else if (d == 8'h30) md = 5;
          end
        endcase
      end
    end
  end
  always #10 begin
    if (md inside {4, 5, 6}) tmr = tmr + 10;
    if (md == 5 && tmr >= TMO_NS) begin
      md = 6;
      tmr = 0;
    end
    if (md inside {4, 6} && tmr >= BUSY_NS) begin
      md = err_i ? 9 : 0;
      erased = 1;
    end
  end
endmodule

// ### sim/flh_ctrl_tb_top.sv
`timescale 1ns/1ns
module flh_ctrl_tb_top;
  localparam logic [22:0] A = 23'h000100;
  localparam logic [22:0] B = 23'h600100;
  localparam logic [15:0] ST = 16'h0040;
  logic clk_sys_i = 0;
  logic rst_i = 1;
  logic cmd_valid_i = 0;
  logic err = 0;
  logic got_ref = 0;
  logic [2:0] cmd_i = 0;
  logic [22:0] addr_i = 0;
  logic [22:0] fa;
  logic ready_o, done_o, refused_o, fail_o, ce_n, oe_n, we_n, rst_n;
  logic dq_oe, rb;
  logic [15:0] rdata_o, dq_h, dq_f, dq_w;
  logic [3:0] mode_o;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  assign dq_w = dq_oe ? dq_h : dq_f;
  // Host window must close before the model's window does
  flh_ctrl #(.BLK_TMO_CYC(100)) i_flh_ctrl (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .addr_i(addr_i), .ready_o(ready_o), .done_o(done_o),
    .refused_o(refused_o), .fail_o(fail_o), .rdata_o(rdata_o),
    .mode_o(mode_o), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .flash_rst_n_o(rst_n), .flash_addr_o(fa),
    .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_w),
    .flash_rb_i(rb));
  flh_flash_model i_flh_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .rst_n_i(rst_n), .err_i(err), .addr_i(fa),
    .dq_i(dq_w), .dq_o(dq_f), .rb_o(rb));
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [2:0] c, input logic [22:0] a);
    int i;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1;
    cmd_i <= c;
    addr_i <= a;
    // Hold the request until an edge samples ready high
    @(posedge clk_sys_i);
    for (i = 0; i < 900 && ready_o !== 1'b1; i++) @(posedge clk_sys_i);
    cmd_valid_i <= 0;
    for (i = 0; i < 900 && done_o !== 1'b1 && refused_o !== 1'b1; i++)
      @(posedge clk_sys_i);
    got_ref = refused_o;
  endtask
  task automatic rd(input logic [22:0] a, input logic [15:0] exp);
    run(7, a);
    chk(rdata_o, exp);
  endtask
  task automatic ckm(input logic [3:0] m);
    chk({12'h000, mode_o}, {12'h000, m});
  endtask
  task automatic wm(input logic [3:0] m);
    for (int i = 0; i < 2000 && mode_o !== m; i++) @(posedge clk_sys_i);
    ckm(m);
  endtask
  task automatic t_query;
    run(1, A);
    ckm(flh_pkg::MD_QRY);
    rd(A, 16'h0051);
    run(0, A);
    ckm(flh_pkg::MD_READ);
    rd(A, 16'h0100);
    $display("query test done");
  endtask
  task automatic t_auto;
    run(2, 23'h000555);
    rd(A, 16'h1234);
    run(1, A);
    ckm(flh_pkg::MD_QRY_AUTO);
    run(0, A);
    rd(A, 16'h1234);
    run(0, A);
    ckm(flh_pkg::MD_READ);
    for (int c = 5; c < 7; c++) begin
      run(c[2:0], A);
      chk({15'h0, got_ref}, 16'h0001);
    end
    $display("auto select test done");
  endtask
  task automatic t_abort;
    run(3, 0);
    ckm(flh_pkg::MD_CHIP);
    rd(A, ST);
    run(5, A);
    chk({15'h0, got_ref}, 16'h0001);
    run(1, A);
    chk({15'h0, got_ref}, 16'h0001);
    rst_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    chk({15'h0, rst_n}, 16'h0000);
    rst_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    ckm(flh_pkg::MD_READ);
    rd(A, 16'h0100);
    $display("abort test done");
  endtask
  task automatic t_block;
    run(4, A);
    ckm(flh_pkg::MD_BTMO);
    run(4, 23'h002000);
    chk({15'h0, got_ref}, 16'h0000);
    rd(A, ST);
    rd(B, 16'h0100);
    run(5, A);
    ckm(flh_pkg::MD_ESUSP);
    rd(B, 16'h0100);
    run(1, A);
    rd(A, 16'h0051);
    run(0, A);
    ckm(flh_pkg::MD_ESUSP);
    run(6, A);
    ckm(flh_pkg::MD_BERASE);
    run(5, A);
    run(6, A);
    ckm(flh_pkg::MD_BERASE);
    wm(flh_pkg::MD_READ);
    rd(B, 16'hFFFF);
    $display("block test done");
  endtask
  task automatic t_err;
    err <= 1;
    run(4, A);
    run(0, A);
    ckm(flh_pkg::MD_READ);
    run(4, A);
    wm(flh_pkg::MD_BERASE);
    run(0, A);
    chk({15'h0, got_ref}, 16'h0001);
    wm(flh_pkg::MD_ERR);
    chk({15'h0, fail_o}, 16'h0001);
    rd(A, 16'h0060);
    run(0, A);
    chk({15'h0, fail_o}, 16'h0000);
    ckm(flh_pkg::MD_READ);
    err <= 0;
    run(3, 0);
    wm(flh_pkg::MD_READ);
    rd(B, 16'hFFFF);
    $display("error and chip test done");
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    t_query;
    t_auto;
    t_abort;
    t_block;
    t_err;
    test_done;
  end
endmodule
